/* File: design/emc_pkg.sv */
`default_nettype none
package emc_pkg;
	// data widths
	localparam int SMP_W = 16;
	localparam int OFS_W = 12;
	localparam int DLY_AW = 5;
	localparam int DLY_DEPTH = 32;
	// phase trim: neutral code and clocks per trim step
	localparam logic [7:0] PHASE_NEUTRAL = 8'h0D;
	localparam int PHASE_STEP_CLK = 4;
	// rate dividers, in master clock periods
	localparam int NYQ_DIV = 8;
	localparam int SMP_DIV = NYQ_DIV / 2;
	localparam int ENERGY_DIV = 4;
	localparam logic [9:0] WAVE_BASE_MASK = 10'h07F;
	localparam int ZXTO_MAX_CLK = 524288;
	localparam int ZXTO_W = 12;
	// mode word: analog sleep bit of the mode register
	localparam logic [5:0] MODE_REG_ADDR = 6'h09;
	localparam int SLEEP_BIT = 4;
	// arithmetic scaling
	localparam int GAIN_FRAC = 12;
	localparam logic [13:0] GAIN_ONE = 14'h1000;
	localparam int AMP_OFS_SHIFT = 15;
	localparam int LPF_SHIFT = 6;
	localparam int PROD_SHIFT = 16;
	// interrupt flag positions
	localparam int FLG_ZX = 0;
	localparam int FLG_LC = 1;
	localparam int FLG_TO = 2;
	localparam int FLG_N = 3;

	typedef struct packed {
		logic [SMP_W-1:0] volt;
		logic [SMP_W-1:0] amp;
	} emc_pair_s;

	typedef enum logic {LC_WAIT, LC_RUN} emc_lc_e;

	typedef struct packed {
		logic [9:0] div_cnt;
		logic [DLY_AW-1:0] wr_ptr;
		logic smp_d;
		logic v_sign;
		logic [SMP_W-1:0] v_cur;
		logic [SMP_W-1:0] a_cur;
		logic [31:0] v_lpf;
		logic [31:0] a_lpf;
		logic [15:0] volt_rms;
		logic [15:0] amp_rms;
		logic [31:0] raw_va;
		logic [GAIN_FRAC-1:0] va_frac;
		logic [31:0] app_acc;
		logic [31:0] act_acc;
		logic [31:0] lc_act;
		logic [31:0] lc_app;
		logic [31:0] lc_act_out;
		logic [31:0] lc_app_out;
		logic [15:0] lc_cnt;
		emc_lc_e lc_st;
		logic lc_done;
		logic [31:0] zx_cnt;
		logic [FLG_N-1:0] flags;
		logic [SMP_W-1:0] wave_v;
		logic [SMP_W-1:0] wave_a;
		logic wave_valid;
	} emc_state_s;

	typedef struct packed {
		emc_pair_s [DLY_DEPTH-1:0] mem;
		logic [SMP_W-1:0] rd_v;
		logic [SMP_W-1:0] rd_a;
	} emc_mem_s;
endpackage
`default_nettype wire

/* File: design/emc_delay_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module emc_delay_mem
	import emc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// write side
	input wire logic wr_en,
	input wire logic [DLY_AW-1:0] wr_addr,
	input wire emc_pair_s wr_data,
	// read side, registered
	input wire logic [DLY_AW-1:0] rd_addr_v,
	input wire logic [DLY_AW-1:0] rd_addr_a,
	output logic [SMP_W-1:0] rd_v,
	output logic [SMP_W-1:0] rd_a
);
	emc_mem_s st;
	emc_mem_s nx;

	// read before write: a same-address read sees the older sample
	always_comb
	begin
		nx = st;
		if (clk_en)
		begin
			nx.rd_v = st.mem[rd_addr_v].volt;
			nx.rd_a = st.mem[rd_addr_a].amp;
			if (wr_en)
				nx.mem[wr_addr] = wr_data;
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= nx;
	end

	assign rd_v = st.rd_v;
	assign rd_a = st.rd_a;
endmodule // emc_delay_mem
`default_nettype wire

/* File: design/emc_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// - rms: square, low-pass, square root
// - volt offset added after square root
// - volt rms offset is 12-bit signed
// - amp offset times 32768 before root
// - apparent energy over divider, times gain
// - interrupt pin can flag voltage zero crossings
// - trim signed, 0x0D neutral, above delays
// - one trim step is four clocks
// - adc nyquist is clock over eight
// - active energy updates every four clocks
// - wave rate clock over 128 to 1024
// - zero-cross timeout reaches 524288 clocks
// - filter cutoffs scale with clock rate
// - serial timing independent of master clock
// - mode bit four suspends analog section
// - suspended: all adc samples forced zero
// - stopped clock halts; restart resumes operation
// - phase shift applied on voltage path
// - neutral trim inserts no voltage delay
module emc_core
	import emc_pkg::*;
#(
	parameter int ZXTO_MAX_CLK_P = ZXTO_MAX_CLK
)(
	// clock, reset, freeze
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// adc sample words
	input wire logic [SMP_W-1:0] volt_sample,
	input wire logic [SMP_W-1:0] amp_sample,
	// calibration and control
	input wire logic [7:0] phase_trim,
	input wire logic [OFS_W-1:0] volt_rms_offset,
	input wire logic [OFS_W-1:0] amp_rms_offset,
	input wire logic [OFS_W-1:0] apparent_gain,
	input wire logic [15:0] apparent_divider,
	input wire logic [1:0] wave_rate_select,
	input wire logic [ZXTO_W-1:0] zero_cross_timeout,
	input wire logic [15:0] line_cycles,
	input wire logic [15:0] mode_word,
	input wire logic [FLG_N-1:0] irq_enable,
	input wire logic [FLG_N-1:0] irq_clear,
	// results
	output logic [15:0] volt_rms_result,
	output logic [15:0] amp_rms_result,
	output logic [31:0] active_energy_acc,
	output logic [31:0] apparent_energy_acc,
	output logic [31:0] line_cycle_active_energy,
	output logic [31:0] line_cycle_apparent_energy,
	output logic line_cycle_done,
	output logic [FLG_N-1:0] irq_status,
	// waveform samples
	output logic [SMP_W-1:0] wave_volt,
	output logic [SMP_W-1:0] wave_amp,
	output logic wave_valid,
	// analog section control
	output logic analog_sleep_bit,
	// open-drain interrupt pin, active low
	output logic irq_n_o,
	output logic irq_n_oe
);
	emc_state_s st;
	emc_state_s nx;
	logic smp;
	logic en_tick;
	logic wave_stb;
	logic zx;
	logic mem_wr;
	emc_pair_s mem_wr_data;
	logic [DLY_AW-1:0] rd_addr_v;
	logic [DLY_AW-1:0] rd_addr_a;
	logic [SMP_W-1:0] rd_v;
	logic [SMP_W-1:0] rd_a;
	logic [15:0] div_eff;
	logic [31:0] raw_sum;
	logic [13:0] fsum;
	logic [31:0] to_limit;
	logic [FLG_N-1:0] flag_set;

	// integer square root, one result bit per step
	function automatic logic [15:0] isqrt(input logic [31:0] x);
		logic [15:0] r;
		logic [15:0] t;
		r = '0;
		for (int i = 15; i >= 0; i--)
		begin
			t = r | (16'h0001 << i);
			if (32'(t) * 32'(t) <= x)
				r = t;
		end
		return r;
	endfunction

	// signed square of a sample
	function automatic logic [31:0] sq(input logic [SMP_W-1:0] v);
		logic signed [31:0] a;
		a = 32'($signed(v));
		return 32'(a * a);
	endfunction

	// first-order low-pass on the squared signal
	function automatic logic [31:0] lpf(input logic [31:0] acc,
		input logic [31:0] x);
		logic [32:0] d;
		d = {1'b0, x} - {1'b0, acc};
		return acc + 32'($signed(d) >>> LPF_SHIFT);
	endfunction

	// voltage rms: root first, then signed offset, clamped
	function automatic logic [15:0] volt_rms_result_calc(input logic [31:0] l,
		input logic [OFS_W-1:0] ofs);
		logic [17:0] s;
		s = 18'(isqrt(l)) + 18'($signed(ofs));
		if (s[17])
			return '0;
		else if (s[16])
			return 16'hFFFF;
		else
			return s[15:0];
	endfunction

	// current rms: offset scaled by 32768 added before root
	function automatic logic [15:0] arms_calc(input logic [31:0] l,
		input logic [OFS_W-1:0] ofs);
		logic [33:0] s;
		s = 34'(l) + (34'($signed(ofs)) << AMP_OFS_SHIFT);
		if (s[33])
			return '0;
		else if (s[32])
			return isqrt(32'hFFFF_FFFF);
		else
			return isqrt(s[31:0]);
	endfunction

	// mask of the waveform divider: 128 clocks shifted by select
	function automatic logic [9:0] wave_mask(input logic [1:0] sel);
		logic [10:0] m;
		m = ({1'b0, WAVE_BASE_MASK} + 11'h001) << sel;
		return 10'(m - 11'h001);
	endfunction

	// voltage delay in samples, clamped to the delay line
	function automatic logic [DLY_AW-1:0] vdly(input logic [7:0] trim);
		if (trim[7])
			return '0;
		else if (trim > 8'(DLY_DEPTH - 1))
			return DLY_AW'(DLY_DEPTH - 1);
		else
			return trim[DLY_AW-1:0];
	endfunction

	// rate strobes from one free counter; serial timing not derived here
	assign smp = (st.div_cnt & 10'(SMP_DIV - 1)) == 10'(SMP_DIV - 1);
	assign en_tick = (st.div_cnt & 10'(ENERGY_DIV - 1))
		== 10'(ENERGY_DIV - 1);
	assign wave_stb = (st.div_cnt & wave_mask(wave_rate_select))
		== wave_mask(wave_rate_select);

	// analog sleep forces samples to zero before they enter the line
	assign analog_sleep_bit = mode_word[SLEEP_BIT];
	assign mem_wr = clk_en && smp;
	assign mem_wr_data = analog_sleep_bit ? '0
		: {volt_sample, amp_sample};

	// current path fixed at neutral depth so trim can also advance voltage
	assign rd_addr_a = st.wr_ptr - DLY_AW'(1) - DLY_AW'(PHASE_NEUTRAL);
	assign rd_addr_v = st.wr_ptr - DLY_AW'(1) - vdly(phase_trim);

	// delay line runs on the master clock enable like everything else
	emc_delay_mem u_dly (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.wr_en(mem_wr),
		.wr_addr(st.wr_ptr),
		.wr_data(mem_wr_data),
		.rd_addr_v(rd_addr_v),
		.rd_addr_a(rd_addr_a),
		.rd_v(rd_v),
		.rd_a(rd_a)
	);

	// zero crossing on each sign change of the delayed voltage
	assign zx = st.smp_d && (rd_v[SMP_W-1] != st.v_sign);

	// apparent scaling terms; zero divider acts as one
	assign div_eff = (apparent_divider == '0) ? 16'h0001 : apparent_divider;
	assign raw_sum = st.raw_va + ((32'(st.volt_rms) * 32'(st.amp_rms))
		>> PROD_SHIFT);
	assign fsum = {2'b00, st.va_frac} + GAIN_ONE
		+ 14'($signed(apparent_gain));
	assign to_limit = (32'(zero_cross_timeout) + 32'h0000_0001)
		* 32'(ZXTO_MAX_CLK_P >> ZXTO_W);

	// next state; frozen whole while the clock enable is low
	always_comb
	begin
		nx = st;
		flag_set = '0;
		if (clk_en)
		begin
			nx.div_cnt = st.div_cnt + 10'h001;
			nx.smp_d = smp;
			nx.lc_done = 1'b0;
			nx.wave_valid = 1'b0;
			if (smp)
				nx.wr_ptr = st.wr_ptr + DLY_AW'(1);
			// filters step at the sample rate, so cutoffs track the clock
			if (st.smp_d)
			begin
				nx.v_cur = rd_v;
				nx.a_cur = rd_a;
				nx.v_sign = rd_v[SMP_W-1];
				nx.v_lpf = lpf(st.v_lpf, sq(rd_v));
				nx.a_lpf = lpf(st.a_lpf, sq(rd_a));
				nx.volt_rms = volt_rms_result_calc(nx.v_lpf, volt_rms_offset);
				nx.amp_rms = arms_calc(nx.a_lpf, amp_rms_offset);
			end
			// energy: up to two apparent units per tick
			if (en_tick)
			begin
				nx.act_acc = st.act_acc + 32'($signed(sq_prod(st.v_cur,
					st.a_cur)) >>> PROD_SHIFT);
				nx.lc_act = st.lc_act + 32'($signed(sq_prod(st.v_cur,
					st.a_cur)) >>> PROD_SHIFT);
				nx.raw_va = raw_sum;
				if (raw_sum >= 32'(div_eff))
				begin
					nx.raw_va = raw_sum - 32'(div_eff);
					nx.va_frac = fsum[GAIN_FRAC-1:0];
					nx.app_acc = st.app_acc + 32'(fsum >> GAIN_FRAC);
					nx.lc_app = st.lc_app + 32'(fsum >> GAIN_FRAC);
				end
			end
			// line-cycle window counted in half cycles
			case (st.lc_st)
				LC_WAIT:
				begin
					if (zx)
					begin
						nx.lc_st = LC_RUN;
						nx.lc_cnt = '0;
						nx.lc_act = '0;
						nx.lc_app = '0;
					end
				end
				LC_RUN:
				begin
					if (zx)
					begin
						nx.lc_cnt = st.lc_cnt + 16'h0001;
						if (st.lc_cnt + 16'h0001 >= line_cycles)
						begin
							nx.lc_act_out = nx.lc_act;
							nx.lc_app_out = nx.lc_app;
							nx.lc_act = '0;
							nx.lc_app = '0;
							nx.lc_cnt = '0;
							nx.lc_done = 1'b1;
							flag_set[FLG_LC] = 1'b1;
						end
					end
				end
				default:
					nx.lc_st = LC_WAIT;
			endcase
			// timeout counter restarts at each crossing, saturates at limit
			if (zx)
				nx.zx_cnt = '0;
			else if (st.zx_cnt != to_limit)
				nx.zx_cnt = st.zx_cnt + 32'h0000_0001;
			if (!zx && st.zx_cnt == to_limit - 32'h0000_0001)
				flag_set[FLG_TO] = 1'b1;
			if (zx)
				flag_set[FLG_ZX] = 1'b1;
			// set beats clear so no event is lost
			nx.flags = (st.flags & ~irq_clear) | flag_set;
			if (wave_stb)
			begin
				nx.wave_v = st.v_cur;
				nx.wave_a = st.a_cur;
				nx.wave_valid = 1'b1;
			end
		end
	end

	// signed product of two samples
	function automatic logic [31:0] sq_prod(input logic [SMP_W-1:0] v,
		input logic [SMP_W-1:0] a);
		logic signed [31:0] x;
		logic signed [31:0] y;
		x = 32'($signed(v));
		y = 32'($signed(a));
		return 32'(x * y);
	endfunction

	// state register
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			st <= '0;
		else
			st <= nx;
	end

	// outputs straight from state
	assign volt_rms_result = st.volt_rms;
	assign amp_rms_result = st.amp_rms;
	assign active_energy_acc = st.act_acc;
	assign apparent_energy_acc = st.app_acc;
	assign line_cycle_active_energy = st.lc_act_out;
	assign line_cycle_apparent_energy = st.lc_app_out;
	assign line_cycle_done = st.lc_done;
	assign irq_status = st.flags;
	assign wave_volt = st.wave_v;
	assign wave_amp = st.wave_a;
	assign wave_valid = st.wave_valid;
	// pin pulled low only while an enabled flag stands
	assign irq_n_o = 1'b0;
	assign irq_n_oe = |(st.flags & irq_enable);

	// checks; aborted while frozen since no time passes then
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n || !clk_en);

	sample_rate_a: assert property (smp |-> ##4 smp)
		else $error("sample strobe period wrong");
	energy_rate_a: assert property (en_tick |=> !en_tick [*3] ##1 en_tick)
		else $error("energy tick period wrong");
	wave_rate_a: assert property (wave_valid |->
		($past(st.div_cnt) & wave_mask($past(wave_rate_select)))
		== wave_mask($past(wave_rate_select)))
		else $error("waveform strobe off its divider");
	sleep_zero_a: assert property (mem_wr && analog_sleep_bit |=>
		u_dly.st.mem[$past(st.wr_ptr)] == '0)
		else $error("sample not zeroed in sleep");
	neutral_trim_a: assert property (phase_trim == PHASE_NEUTRAL |->
		rd_addr_v == rd_addr_a)
		else $error("neutral trim shifts voltage");
	trim_delay_a: assert property (!phase_trim[7]
		&& phase_trim > PHASE_NEUTRAL && phase_trim < 8'(DLY_DEPTH) |->
		DLY_AW'(rd_addr_a - rd_addr_v)
		== DLY_AW'(phase_trim - PHASE_NEUTRAL))
		else $error("trim delay mismatch");
	volt_rms_a: assert property (st.smp_d |=> volt_rms_result
		== volt_rms_result_calc($past(nx.v_lpf), $past(volt_rms_offset)))
		else $error("voltage rms offset misapplied");
	amp_rms_a: assert property (st.smp_d |=> amp_rms_result
		== arms_calc($past(nx.a_lpf), $past(amp_rms_offset)))
		else $error("current rms offset misapplied");
	app_scale_a: assert property (en_tick && raw_sum >= 32'(div_eff) |=>
		apparent_energy_acc == $past(apparent_energy_acc)
		+ 32'($past(fsum) >> GAIN_FRAC))
		else $error("apparent scaling wrong");
	zx_irq_a: assert property (zx && irq_enable[FLG_ZX]
		&& $stable(irq_enable) |=> irq_status[FLG_ZX]
		&& (!irq_enable[FLG_ZX] || (irq_n_oe && !irq_n_o)))
		else $error("zero crossing not on pin");
	timeout_a: assert property ($rose(irq_status[FLG_TO]) |->
		$past(st.zx_cnt) == $past(to_limit) - 32'h0000_0001)
		else $error("timeout at wrong count");

	zx_seen_c: cover property (zx);
	lc_done_c: cover property (line_cycle_done);
	timeout_c: cover property ($rose(irq_status[FLG_TO]));
	sleep_c: cover property (mem_wr && analog_sleep_bit);
endmodule // emc_core
`default_nettype wire

/* File: tb/emc_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module emc_adc_model
	import emc_pkg::*;
(
	// clock and freeze
	input wire logic sys_clk,
	input wire logic clk_en,
	// 0 ramp, 1 constant, 2 alternating sign
	input wire logic [1:0] mode,
	input wire logic [SMP_W-1:0] level,
	// adc words
	output logic [SMP_W-1:0] volt_sample,
	output logic [SMP_W-1:0] amp_sample
);
	logic [1:0] phase_r;
	initial
	begin
		phase_r = 2'h0;
		volt_sample = 16'h0000;
	end
	// new word every fourth running clock; a stopped clock stops the adc too
	always @(posedge sys_clk)
	begin
		if (clk_en)
		begin
			phase_r <= phase_r + 2'h1;
			if (phase_r == 2'h0)
			begin
				case (mode)
				2'h0: volt_sample <= volt_sample + 16'h0001;
				2'h2: volt_sample <= (volt_sample == level) ? -level : level;
				default: volt_sample <= level;
				endcase
			end
		end
	end
	// same word on both channels, so any trim shows as a plain difference
	assign amp_sample = volt_sample;
endmodule // emc_adc_model
`default_nettype wire

/* File: tb/test_energy_meter_calibration_dsp.sv */
`timescale 1ns/1ps
`default_nettype none
module test_energy_meter_calibration_dsp
	import emc_pkg::*;
();
	typedef struct packed {
		logic zero;
		logic [15:0] diff;
	} emc_note_s;
	logic sys_clk, reset_n, clk_en, wave_valid, analog_sleep_bit;
	logic irq_n_o, irq_n_oe;
	logic [1:0] adc_mode, wave_rate_select;
	logic [7:0] phase_trim;
	logic [15:0] adc_level, volt_sample, amp_sample, mode_word;
	logic [15:0] apparent_divider, line_cycles, wave_volt, wave_amp;
	logic [15:0] volt_rms_result, amp_rms_result;
	logic [OFS_W-1:0] volt_rms_offset, amp_rms_offset, apparent_gain;
	logic [ZXTO_W-1:0] zero_cross_timeout;
	logic [FLG_N-1:0] irq_enable, irq_clear, irq_status;
	logic [31:0] active_energy_acc, apparent_energy_acc;
	logic [31:0] line_cycle_active_energy, line_cycle_apparent_energy;
	logic line_cycle_done;
	logic [31:0] acc_q[9];
	logic [7:0] trims[5] = '{8'h0D, 8'h0E, 8'h0B, 8'h1F, 8'h00};
	emc_note_s notes[$];
	emc_note_s n;
	int num_errors, samples_checked, seed, w, v0, a0, a1, ofs_v, ofs_a, chg;

	emc_adc_model i_adc (.sys_clk(sys_clk), .clk_en(clk_en), .mode(adc_mode),
		.level(adc_level), .volt_sample(volt_sample), .amp_sample(amp_sample));

	// timeout unit shrunk to one clock to keep the run short
	emc_core #(.ZXTO_MAX_CLK_P(4096)) i_dut (.sys_clk(sys_clk),
		.reset_n(reset_n), .clk_en(clk_en), .volt_sample(volt_sample),
		.amp_sample(amp_sample), .phase_trim(phase_trim),
		.volt_rms_offset(volt_rms_offset), .amp_rms_offset(amp_rms_offset),
		.apparent_gain(apparent_gain), .apparent_divider(apparent_divider),
		.wave_rate_select(wave_rate_select),
		.zero_cross_timeout(zero_cross_timeout), .line_cycles(line_cycles),
		.mode_word(mode_word), .irq_enable(irq_enable), .irq_clear(irq_clear),
		.volt_rms_result(volt_rms_result), .amp_rms_result(amp_rms_result),
		.active_energy_acc(active_energy_acc),
		.apparent_energy_acc(apparent_energy_acc),
		.line_cycle_active_energy(line_cycle_active_energy),
		.line_cycle_apparent_energy(line_cycle_apparent_energy),
		.line_cycle_done(line_cycle_done), .irq_status(irq_status),
		.wave_volt(wave_volt),
		.wave_amp(wave_amp), .wave_valid(wave_valid),
		.analog_sleep_bit(analog_sleep_bit), .irq_n_o(irq_n_o),
		.irq_n_oe(irq_n_oe));

	// 250 MHz master clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic check_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// counts clocks up to the next strobe, bounded
	task automatic wait_wave(output int k);
		k = 0;
		do
		begin
			@(negedge sys_clk);
			k++;
		end
		while (wave_valid !== 1'b1 && k < 1100);
	endtask

	task automatic wait_notes();
		int k;
		k = 0;
		while (notes.size() > 0 && k < 3000)
		begin
			@(posedge sys_clk);
			k++;
		end
		check_val("notes left", 0, notes.size());
	endtask

	// monitor: each strobe settles the oldest note, sampled mid-cycle
	always @(negedge sys_clk)
	begin
		if (wave_valid === 1'b1 && notes.size() > 0)
		begin
			n = notes.pop_front();
			if (n.zero)
				check_val("wave zero", 0, {wave_volt, wave_amp});
			else
				check_val("wave lag", n.diff, 16'(wave_amp - wave_volt));
		end
	end

	// watchdog, about twice the expected run
	initial
	begin
		#160000;
		num_errors++;
		test_done();
	end

	initial
	begin
		seed = 43;
		reset_n = 1'b0;
		clk_en = 1'b1;
		adc_mode = 2'h0;
		adc_level = 16'h4000;
		phase_trim = PHASE_NEUTRAL;
		volt_rms_offset = 12'h000;
		amp_rms_offset = 12'h000;
		apparent_gain = 12'($random(seed));
		apparent_divider = 16'($random(seed));
		line_cycles = 16'h0004;
		wave_rate_select = 2'h0;
		zero_cross_timeout = 12'hFFF;
		mode_word = 16'h0000;
		irq_enable = 3'h0;
		irq_clear = 3'h0;
		tick(4);
		reset_n <= 1'b1;
		// ramp input: lag between channels is the trim offset in samples
		foreach (trims[i])
		begin
			phase_trim <= trims[i];
			tick(300);
			repeat (2) notes.push_back('{1'b0, {8'h00, trims[i]} - 16'h000D});
			wait_notes();
		end
		// strobe spacing for every rate code
		for (int s = 0; s < 4; s++)
		begin
			tick(1);
			wave_rate_select <= 2'(s);
			repeat (3) wait_wave(w);
			check_val("wave period", 128 << s, w);
		end
		tick(1);
		wave_rate_select <= 2'h0;
		// analog sleep blanks every sample
		mode_word <= 16'h0010;
		tick(400);
		check_val("sleep bit", 1, analog_sleep_bit);
		repeat (2) notes.push_back('{1'b1, 16'h0000});
		wait_notes();
		// wake, then freeze the clock and check the active energy holds
		mode_word <= 16'h0000;
		tick(200);
		clk_en <= 1'b0;
		tick(2);
		acc_q[0] = active_energy_acc;
		tick(300);
		check_val("frozen energy", acc_q[0], active_energy_acc);
		clk_en <= 1'b1;
		repeat (2) notes.push_back('{1'b0, 16'hFFF3});
		wait_notes();
		// constant level: energy steps once every four clocks
		adc_mode <= 2'h1;
		tick(200);
		foreach (acc_q[k])
		begin
			@(negedge sys_clk);
			acc_q[k] = active_energy_acc;
		end
		chg = 0;
		for (int k = 0; k < 8; k++)
			chg += (acc_q[k + 1] !== acc_q[k]);
		check_val("energy updates", 2, chg);
		check_val("energy step", 2 * ((32'h4000 * 32'h4000) >> PROD_SHIFT),
			acc_q[8] - acc_q[0]);
		// rms offsets: voltage after the root, current before it
		tick(6000);
		@(negedge sys_clk);
		v0 = volt_rms_result;
		a0 = amp_rms_result;
		ofs_v = $random(seed) % 100;
		ofs_a = $random(seed) % 100;
		tick(1);
		volt_rms_offset <= 12'(ofs_v);
		amp_rms_offset <= 12'(ofs_a);
		tick(12);
		@(negedge sys_clk);
		a1 = amp_rms_result;
		check_val("volt rms", v0 + ofs_v, volt_rms_result);
		check_val("amp rms", 1, a1 * a1 < (a0 + 1) * (a0 + 1) + 32768 * ofs_a
			&& (a1 + 1) * (a1 + 1) > a0 * a0 + 32768 * ofs_a);
		// zero crossings drive the pin only while enabled
		tick(1);
		adc_mode <= 2'h2;
		irq_enable <= 3'b001;
		tick(100);
		@(negedge sys_clk);
		check_val("zx pin", 3'b110, {irq_status[0], irq_n_oe, irq_n_o});
		tick(1);
		irq_enable <= 3'b000;
		tick(2);
		check_val("pin masked", 0, irq_n_oe);
		// host samples the apparent energy total as each of two windows closes
		repeat (2)
		begin
			w = 0;
			do
			begin
				@(negedge sys_clk);
				w++;
			end
			while (line_cycle_done !== 1'b1 && w < 100);
			acc_q[1] = acc_q[0];
			acc_q[0] = apparent_energy_acc;
		end
		// odd lag of 13 samples on alternating input: every product negative
		check_val("lc flag", 1, irq_status[FLG_LC]);
		check_val("lc active", -32'(line_cycles)
			* ((32'h4000 * 32'h4000) >> PROD_SHIFT),
			line_cycle_active_energy);
		check_val("lc apparent", acc_q[0] - acc_q[1],
			line_cycle_apparent_energy);
		// squares match the constant level, so rms read at a crossing holds
		check_val("rms at crossing", v0 + ofs_v, volt_rms_result);
		check_val("amp rms at crossing", a1, amp_rms_result);
		tick(1);
		// no crossings: timeout flag only after the full span
		adc_mode <= 2'h1;
		tick(150);
		irq_clear <= 3'b111;
		tick(1);
		irq_clear <= 3'b000;
		tick(2000);
		check_val("early timeout", 0, irq_status);
		tick(2200);
		check_val("timeout flag", 1, irq_status[2]);
		test_done();
	end
endmodule // test_energy_meter_calibration_dsp
`default_nettype wire
